/* File: obsl_map.vh */
`ifndef OBSL_MAP_VH
`define OBSL_MAP_VH
// Flash information block byte addresses of the option bytes
`define OBSL_FLASH_BYTE_ZERO_ADDR 8'hFE
`define OBSL_FLASH_BYTE_ONE_ADDR 8'hFF
// Register file addresses of the shadows
`define OBSL_REG_BYTE_ZERO_ADDR 8'hFE
`define OBSL_REG_BYTE_ONE_ADDR 8'hFD
`define OBSL_REG_PROT_ADDR 8'hFC
// Option byte zero field positions
`define OBSL_BIT_WATCHDOG 7
`define OBSL_BIT_PORT4_PULLUP 6
`define OBSL_BIT_PORT3_PULLUP 5
`define OBSL_BIT_PORT2_PULLUP 4
`define OBSL_BIT_PORT1_HIGH 3
`define OBSL_BIT_PORT1_LOW 2
`define OBSL_BIT_PORT0_HIGH 1
`define OBSL_BIT_PORT0_LOW 0
// Option byte one field positions
`define OBSL_BIT_STACK16 3
`define OBSL_BIT_NODIV 2
`define OBSL_BIT_LOWPROT 1
`define OBSL_BIT_PROT 0
// Writable and implemented bits of the option byte one shadow
`define OBSL_BYTE_ONE_CPU_MASK 8'h0C
`define OBSL_BYTE_ONE_IMPL_MASK 8'h0F
// Predefined values forced at the start of reset
`define OBSL_BYTE_ZERO_RESET 8'hFF
`define OBSL_BYTE_ONE_RESET 8'h00
`define OBSL_PROT_RESET 2'h0
// Stop-recovery control bit that selects option reload
`define OBSL_STOP_RELOAD_BIT 5
// Last wait count of a flash byte read, so each byte address is held for three cycles
`define OBSL_FLASH_WAIT 2'h2
`endif

/* File: obsl_loader.v */
// Function
// [RL1] Copy all option bits from flash during the last cycles of power-on or selected stop-recovery reset.
// [RL2] Force shadows to predefined values at the start of reset.
// [RL3] New flash option values only take effect after a later reset.
// [RL4] Fetch option bytes from information block addresses FFh and FEh.
// [RL5] CPU may read and write all shadows except bits 1 and 0 of option byte one.
// [RL6] Shadow outputs are not trusted until loading is complete.
// [RL7] Option byte zero holds watchdog, port 4, 3, 2, 1 high, 1 low, 0 high, 0 low pull-up bits.
// [RL8] A pull-up bit of 1 disables the pull-ups and 0 enables them.
// [RL9] At power-on reset bits 1 and 0 of option byte one are captured into readable protect flops.
// [RL10] CPU writes never change the protect flops.
// [RL11] Option byte one is changed only through the in-circuit programming port.
// [RL12] With protect bit 0 both flash interfaces are blocked unless mass erase completed.
// [RL13] Mass erase sets the shadow protect bit to 1, flash bit unchanged, granting full access.
// [RL14] Reserved shadow bits read 0 and ignore writes.
// [RL15] Signal load completion so the CPU is released only afterwards.
`timescale 1ns/1ps
`default_nettype none
`include "obsl_map.vh"
module obsl_loader
(
	// Clock and reset
	input  wire       core_clk,
	input  wire       arst_n,
	// Reset sequencer
	input  wire       por_load,
	input  wire       stop_recovery_load,
	input  wire [7:0] stop_recovery_control,
	output reg        load_done,
	// Flash information block read port
	output reg        flash_rd,
	output reg  [7:0] flash_addr,
	input  wire [7:0] flash_rdata,
	// Flash access control
	input  wire       in_circuit_programming_port,
	input  wire       mass_erase_done,
	input  wire       flash_option_one_wr,
	output wire       main_access_ok,
	output wire       page3_wr_ok,
	output wire       option_one_wr_ok,
	// CPU register file port
	input  wire       reg_wr,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	// Option outputs
	output wire       watchdog_always_on,
	output wire       port_four_pullup_off,
	output wire       port_three_pullup_off,
	output wire       port_two_pullup_off,
	output wire       port_one_high_pullup_off,
	output wire       port_one_low_pullup_off,
	output wire       port_zero_high_pullup_off,
	output wire       port_zero_low_pullup_off,
	output wire       clock_no_divide,
	output wire       stack_wide,
	output wire       main_memory_protect,
	output wire       lower_half_protect
);

	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_RD0  = 4'b0010;
	localparam [3:0] ST_RD1  = 4'b0100;
	localparam [3:0] ST_DONE = 4'b1000;

	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [1:0] wait_r;
	reg [1:0] wait_nxt;
	reg       por_sel_r;
	reg [7:0] user_option_byte_zero_r;
	reg [7:0] option_one_shadow_r;
	reg [1:0] prot_ff_r;
	reg       erased_r;

	// Register file decode; the two shadow decodes are shared by the write and the read paths, the protect decode is read only
	function hit_byte_zero;
		input [7:0] addr;
		begin
			hit_byte_zero = (addr == `OBSL_REG_BYTE_ZERO_ADDR);
		end
	endfunction

	function hit_byte_one;
		input [7:0] addr;
		begin
			hit_byte_one = (addr == `OBSL_REG_BYTE_ONE_ADDR);
		end
	endfunction

	function hit_prot;
		input [7:0] addr;
		begin
			hit_prot = (addr == `OBSL_REG_PROT_ADDR);
		end
	endfunction

	// Keeps the CPU away from the protect bits and the reserved bits
	function [7:0] merge_byte_one;
		input [7:0] old_val;
		input [7:0] cpu_val;
		begin
			merge_byte_one = (old_val & ~`OBSL_BYTE_ONE_CPU_MASK) |
				(cpu_val & `OBSL_BYTE_ONE_CPU_MASK);
		end
	endfunction

	wire      reload_req;
	wire      load_start;
	wire      wait_end;
	wire      byte_zero_cap;
	wire      byte_one_cap;
	wire      cpu_wr_zero;
	wire      cpu_wr_one;

	assign reload_req    = por_load |
		(stop_recovery_load & stop_recovery_control[`OBSL_STOP_RELOAD_BIT]); // RL1
	// A request during a fetch is ignored so the two bytes always pair up
	assign load_start    = reload_req && (state_r == ST_IDLE || state_r == ST_DONE);
	assign wait_end      = (wait_r == `OBSL_FLASH_WAIT);
	assign byte_zero_cap = (state_r == ST_RD0) && wait_end;
	assign byte_one_cap  = (state_r == ST_RD1) && wait_end;
	assign cpu_wr_zero   = reg_wr && hit_byte_zero(reg_addr);
	assign cpu_wr_one    = reg_wr && hit_byte_one(reg_addr);

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (reload_req) state_nxt = ST_RD0;
			ST_RD0:  if (wait_end) state_nxt = ST_RD1;
			ST_RD1:  if (wait_end) state_nxt = ST_DONE;
			ST_DONE: if (reload_req) state_nxt = ST_RD0; // RL3
			default: state_nxt = ST_IDLE;
		endcase
	end

	// Wait counter runs only inside the two read states
	always @*
	begin
		wait_nxt = wait_r + 2'h1;
		if (state_r != state_nxt || state_r == ST_IDLE || state_r == ST_DONE)
			wait_nxt = 2'h0;
	end

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_r   <= ST_IDLE;
			wait_r    <= 2'h0;
			por_sel_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			wait_r  <= wait_nxt;
			if (load_start)
				por_sel_r <= por_load;
		end
	end

	// Driven from the next state so the address is settled for the whole read
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			load_done  <= 1'b0;
			flash_rd   <= 1'b0;
			flash_addr <= 8'h00;
		end
		else
		begin
			load_done <= (state_nxt == ST_DONE); // RL6 RL15
			flash_rd  <= (state_nxt == ST_RD0) || (state_nxt == ST_RD1);
			if (state_nxt == ST_RD1)
				flash_addr <= `OBSL_FLASH_BYTE_ONE_ADDR; // RL4
			else
				flash_addr <= `OBSL_FLASH_BYTE_ZERO_ADDR; // RL4
		end
	end

	// A flash load wins over a CPU write in the same cycle
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			user_option_byte_zero_r <= `OBSL_BYTE_ZERO_RESET; // RL2
		else if (byte_zero_cap)
			user_option_byte_zero_r <= flash_rdata; // RL1 RL7 RL8
		else if (cpu_wr_zero)
			user_option_byte_zero_r <= reg_wdata; // RL5
	end

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			option_one_shadow_r <= `OBSL_BYTE_ONE_RESET; // RL2
		else
		begin
			if (byte_one_cap)
				option_one_shadow_r <= flash_rdata & `OBSL_BYTE_ONE_IMPL_MASK; // RL1 RL14
			else if (cpu_wr_one)
				option_one_shadow_r <= merge_byte_one(option_one_shadow_r, reg_wdata); // RL5
			// Mass erase has the last word on the protect bit
			if (mass_erase_done)
				option_one_shadow_r[`OBSL_BIT_PROT] <= 1'b1; // RL13
		end
	end

	// Captured on power-on loads only; no CPU path reaches these flops
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			prot_ff_r <= `OBSL_PROT_RESET;
		else if (byte_one_cap && por_sel_r)
			prot_ff_r <= flash_rdata[`OBSL_BIT_LOWPROT:`OBSL_BIT_PROT]; // RL9 RL10
	end

	// Sticky so protection stays lifted until the next power-on capture
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			erased_r <= 1'b0;
		else if (mass_erase_done)
			erased_r <= 1'b1; // RL13
		else if (byte_one_cap && por_sel_r)
			erased_r <= 1'b0;
	end

	// Protect flops reflect power-on capture, main_memory_protect lifted only by mass erase
	assign main_memory_protect = prot_ff_r[`OBSL_BIT_PROT] | erased_r; // RL12 RL13
	assign lower_half_protect  = prot_ff_r[`OBSL_BIT_LOWPROT];
	assign main_access_ok      = load_done & main_memory_protect; // RL12
	assign page3_wr_ok         = load_done & main_memory_protect; // RL12
	assign option_one_wr_ok    = page3_wr_ok & in_circuit_programming_port &
		flash_option_one_wr; // RL11

	assign watchdog_always_on        = user_option_byte_zero_r[`OBSL_BIT_WATCHDOG]; // RL7
	assign port_four_pullup_off      = user_option_byte_zero_r[`OBSL_BIT_PORT4_PULLUP]; // RL8
	assign port_three_pullup_off     = user_option_byte_zero_r[`OBSL_BIT_PORT3_PULLUP];
	assign port_two_pullup_off       = user_option_byte_zero_r[`OBSL_BIT_PORT2_PULLUP];
	assign port_one_high_pullup_off  = user_option_byte_zero_r[`OBSL_BIT_PORT1_HIGH];
	assign port_one_low_pullup_off   = user_option_byte_zero_r[`OBSL_BIT_PORT1_LOW];
	assign port_zero_high_pullup_off = user_option_byte_zero_r[`OBSL_BIT_PORT0_HIGH];
	assign port_zero_low_pullup_off  = user_option_byte_zero_r[`OBSL_BIT_PORT0_LOW];
	assign clock_no_divide           = option_one_shadow_r[`OBSL_BIT_NODIV];
	assign stack_wide                = option_one_shadow_r[`OBSL_BIT_STACK16];

	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= 8'h00;
		else if (hit_byte_zero(reg_addr))
			reg_rdata <= user_option_byte_zero_r;
		else if (hit_byte_one(reg_addr))
			reg_rdata <= option_one_shadow_r & `OBSL_BYTE_ONE_IMPL_MASK; // RL14
		else if (hit_prot(reg_addr))
			reg_rdata <= {6'h00, lower_half_protect, main_memory_protect}; // RL9
		else
			reg_rdata <= 8'h00;
	end

endmodule // obsl_loader
`default_nettype wire

/* File: obsl_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module obsl_flash_model (
	input  wire logic       rd,
	input  wire logic [7:0] addr, b0, b1,
	output logic      [7:0] rdata
);
	// Idle data is junk (5Ah) so a sample taken off the read window is caught, except where the expected byte is 5Ah
	assign rdata = !rd ? 8'h5A : addr == 8'hFE ? b0 : addr == 8'hFF ? b1 : 8'hC3;
endmodule // obsl_flash_model
`default_nettype wire

/* File: obsl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module obsl_checker (
	input wire logic core_clk, arst_n, por_load, stop_recovery_load, load_done, flash_rd,
	input wire logic mass_erase_done, in_circuit_programming_port, main_access_ok, page3_wr_ok,
	input wire logic option_one_wr_ok, lower_half_protect,
	input wire logic [7:0] stop_recovery_control, flash_addr, reg_addr, reg_rdata
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_fetch;
		(flash_addr == 8'hFE) [*3] ##1 (flash_addr == 8'hFF) [*3];
	endsequence
	chk_load_latency: assert property ($rose(por_load) |-> ##7 load_done)
		else $error("late done");
	chk_stop_gate: assert property (stop_recovery_load && !stop_recovery_control[5] && load_done
		|=> load_done)
		else $error("ungated reload");
	chk_fetch_order: assert property ($rose(flash_rd) |-> s_fetch)
		else $error("fetch order");
	chk_done_idle: assert property (load_done |-> !flash_rd)
		else $error("done in fetch");
	chk_prot_hold: assert property (!flash_rd |=> $stable(lower_half_protect))
		else $error("protect moved");
	chk_erase_open: assert property (mass_erase_done |=> main_access_ok && page3_wr_ok)
		else $error("erase closed");
	chk_port_only: assert property (option_one_wr_ok |-> in_circuit_programming_port)
		else $error("option byte one write");
	chk_resv_zero: assert property ($past(reg_addr) == 8'hFD |-> reg_rdata[7:4] == 4'h0)
		else $error("reserved set");
endmodule // obsl_checker
bind obsl_loader obsl_checker u_chk (.*);
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic core_clk = 0, arst_n = 0, por_load = 0, stop_recovery_load = 0;
	logic in_circuit_programming_port = 0, flash_option_one_wr = 0;
	logic mass_erase_done = 0, reg_wr = 0, load_done, flash_rd;
	logic main_access_ok, page3_wr_ok, option_one_wr_ok, clock_no_divide, stack_wide;
	logic main_memory_protect, lower_half_protect, watchdog_always_on, port_four_pullup_off;
	logic port_three_pullup_off, port_two_pullup_off, port_one_high_pullup_off;
	logic port_one_low_pullup_off, port_zero_high_pullup_off, port_zero_low_pullup_off;
	logic [7:0] stop_recovery_control = 0, reg_addr = 0, reg_wdata = 0, b0 = 0, b1 = 0;
	logic [7:0] flash_addr, flash_rdata, reg_rdata;
	int err_count = 0, compares = 0;
	wire logic [7:0] pu = {watchdog_always_on, port_four_pullup_off, port_three_pullup_off,
		port_two_pullup_off, port_one_high_pullup_off, port_one_low_pullup_off,
		port_zero_high_pullup_off, port_zero_low_pullup_off};
	wire logic [3:0] cfg = {stack_wide, clock_no_divide, main_memory_protect, lower_half_protect};
	obsl_loader dut (.*);
	obsl_flash_model u_fl (.rd(flash_rd), .addr(flash_addr), .b0(b0), .b1(b1), .rdata(flash_rdata));
	always #25 core_clk = ~core_clk;
	task automatic chk(input string nm, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict;
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(negedge core_clk) reg_addr = a;
		@(negedge core_clk) chk("reg_rdata", reg_rdata, exp);
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(negedge core_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'h1};
		@(negedge core_clk) reg_wr = 0;
	endtask
	task automatic ld(input logic por);
		@(negedge core_clk) {por_load, stop_recovery_load} = {por, !por};
		@(negedge core_clk) {por_load, stop_recovery_load} = 2'h0;
		repeat (8) @(negedge core_clk);
	endtask
	task automatic t_por;
		rd(8'hFE, 8'hFF);
		{b0, b1} = 16'h5A0E;
		ld(1);
		chk("load_done", {7'h0, load_done}, 8'h01);
		chk("pullups", pu, 8'h5A);
		chk("main_access_ok", {7'h0, main_access_ok}, 8'h00);
		chk("cfg", {4'h0, cfg}, 8'h0D);
		rd(8'hFE, 8'h5A);
		rd(8'hFD, 8'h0E);
		rd(8'hFC, 8'h02);
	endtask
	task automatic t_cpu;
		wr(8'hFD, 8'hF1);
		rd(8'hFD, 8'h02);
		chk("cfg", {4'h0, cfg}, 8'h01);
		wr(8'hFC, 8'h01);
		rd(8'hFC, 8'h02);
		wr(8'hFE, 8'hA5);
		chk("pullups", pu, 8'hA5);
	endtask
	task automatic t_reload;
		{b0, b1} = 16'h3C0C;
		rd(8'hFE, 8'hA5);
		ld(0);
		rd(8'hFE, 8'hA5);
		stop_recovery_control = 8'h20;
		ld(0);
		rd(8'hFE, 8'h3C);
		rd(8'hFC, 8'h02);
		chk("cfg", {4'h0, cfg}, 8'h0D);
	endtask
	task automatic t_erase;
		chk("option_one_wr_ok", {7'h0, option_one_wr_ok}, 8'h00);
		@(negedge core_clk) {in_circuit_programming_port, flash_option_one_wr} = 2'h3;
		@(negedge core_clk) chk("option_one_wr_ok", {7'h0, option_one_wr_ok}, 8'h00);
		mass_erase_done = 1;
		@(negedge core_clk) mass_erase_done = 0;
		chk("access", {6'h0, main_access_ok, page3_wr_ok}, 8'h03);
		chk("option_one_wr_ok", {7'h0, option_one_wr_ok}, 8'h01);
		@(negedge core_clk) in_circuit_programming_port = 0;
		@(negedge core_clk) chk("option_one_wr_ok", {7'h0, option_one_wr_ok}, 8'h00);
		rd(8'hFD, 8'h0D);
		rd(8'hFC, 8'h03);
	endtask
	task automatic t_rst;
		@(negedge core_clk) arst_n = 0;
		repeat (2) @(negedge core_clk);
		arst_n = 1;
		chk("load_done", {7'h0, load_done}, 8'h00);
		rd(8'hFE, 8'hFF);
		rd(8'hFD, 8'h00);
	endtask
	initial
	begin
		repeat (12) @(negedge core_clk);
		arst_n = 1;
		t_por;
		t_cpu;
		t_reload;
		t_erase;
		t_rst;
		print_verdict;
	end
	initial
	begin
		#100000;
		err_count++;
		print_verdict;
	end
endmodule // tb
`default_nettype wire
